// *** src/dsc_defs.vh ***
// constants for the debug identification and secure debug control block
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH
`define DSC_ADDR_CTRL      32'he000ee08
`define DSC_ADDR_ID4       32'he000efd0
`define DSC_ADDR_ID5       32'he000efd4
`define DSC_ADDR_ID6       32'he000efd8
`define DSC_ADDR_ID7       32'he000efdc
`define DSC_ADDR_ID3       32'he000efec
`define DSC_ALIAS_OFFSET   32'h00020000
`define DSC_BIT_KEY        17
`define DSC_BIT_SECURE     16
`define DSC_BIT_BANK_SEL   1
`define DSC_BIT_BANK_EN    0
`define DSC_FLD_HI_MSB     7
`define DSC_FLD_HI_LSB     4
`define DSC_FLD_LO_MSB     3
`define DSC_FLD_LO_LSB     0
`define DSC_RST_BANK_SEL   1'b0
`define DSC_RST_BANK_EN    1'b0
`define DSC_RST_SECURE     1'b1
`endif

// *** src/dsc_addr_decode.v ***
// address decoder: matches the identification words and their alias
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defs.vh"
module dsc_addr_decode
(
  input  wire [31:0] addr_in,        // byte address of the access
  output reg  [2:0]  ident_idx_out,  // 0..4 = word 3,4,5,6,7
  output reg         ident_hit_out,  // primary identification hit
  output reg         alias_hit_out,  // non-secure alias hit
  output wire        ctrl_hit_out    // control register hit
);
  // identification index lookup, shared by primary and alias
  function [3:0] ident_match;
    input [31:0] a;
    begin
      case (a)
        `DSC_ADDR_ID3: ident_match = 4'h8;
        `DSC_ADDR_ID4: ident_match = 4'h9;
        `DSC_ADDR_ID5: ident_match = 4'ha;
        `DSC_ADDR_ID6: ident_match = 4'hb;
        `DSC_ADDR_ID7: ident_match = 4'hc;
        default:       ident_match = 4'h0;
      endcase
    end
  endfunction

  reg [3:0] prim_m; // primary match
  reg [3:0] alias_m; // alias match

  assign ctrl_hit_out = (addr_in == `DSC_ADDR_CTRL);

  // combine primary and alias matches
  always @*
  begin
    prim_m = ident_match(addr_in);
    alias_m = ident_match(addr_in - `DSC_ALIAS_OFFSET);
    ident_hit_out = prim_m[3];
    alias_hit_out = alias_m[3];
    if (prim_m[3])
      ident_idx_out = prim_m[2:0];
    else
      ident_idx_out = alias_m[2:0];
  end
endmodule
`default_nettype wire

// *** src/dsc_ctrl_reg.v ***
// debug security control state: secure state, bank select and enable
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defs.vh"
module dsc_ctrl_reg
(
  input  wire        ref_clk_in,        // system clock
  input  wire        rst_n_in,          // cold reset, sync, active low
  input  wire        wr_en_in,          // qualified debugger write
  input  wire [31:0] wdata_in,          // write data
  input  wire        secure_debug_enable_in, // secure debug allowed
  input  wire        halted_in,         // processor halted in debug state
  output wire        secure_state_out,  // current secure state
  output wire [31:0] rdata_out          // read view of the register
);
  reg secure_q;    // current security state
  reg bank_sel_q;  // bank view select
  reg bank_en_q;   // bank view select enable

  // state updates, only on a debugger write while halted
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      secure_q   <= `DSC_RST_SECURE;
      bank_sel_q <= `DSC_RST_BANK_SEL;
      bank_en_q  <= `DSC_RST_BANK_EN;
    end
    else if (wr_en_in && halted_in)
    begin
      // secure state needs key written zero and secure debug on
      if (secure_debug_enable_in && !wdata_in[`DSC_BIT_KEY])
        secure_q <= wdata_in[`DSC_BIT_SECURE];
      if (secure_debug_enable_in)
      begin
        bank_sel_q <= wdata_in[`DSC_BIT_BANK_SEL];
        bank_en_q  <= wdata_in[`DSC_BIT_BANK_EN];
      end
    end
  end

  assign secure_state_out = secure_q;

  // read value: key reads one, reserved bits zero
  assign rdata_out = {14'h0000, 1'b1, secure_q, 14'h0000,
                      bank_sel_q & secure_debug_enable_in,
                      bank_en_q | ~secure_debug_enable_in};
endmodule
`default_nettype wire

// *** src/dsc_regbank.v ***
// register bank: identification words and secure debug control
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defs.vh"
module dsc_regbank
#(
  parameter       HAS_IDENT      = 1,    // identification scheme present
  parameter       HAS_HALT_DEBUG = 1,    // halting debug present
  parameter       HAS_SECURITY   = 1,    // security extension present
  parameter       HAS_MAIN_EXT   = 1,    // main extension present
  parameter       IDENT_DBG_ONLY = 0,    // hide ids from software (no main ext)
  parameter [3:0] REVISION_AND   = 4'h0, // revision-and field, arbitrary
  parameter [3:0] CUSTOMER_MOD   = 4'h0, // customer modified field, arbitrary
  parameter [3:0] CONTINUATION   = 4'h0  // continuation code, arbitrary
)
(
  input  wire        ref_clk_in,        // system clock
  input  wire        rst_n_in,          // cold reset, sync, active low
  input  wire        req_in,            // access request, one cycle
  input  wire        write_in,          // 1 write, 0 read
  input  wire [31:0] addr_in,           // byte address
  input  wire [31:0] wdata_in,          // write data
  input  wire        privileged_in,     // access is privileged
  input  wire        from_debugger_in,  // access comes from debugger
  input  wire        sw_secure_in,      // software access is secure
  input  wire        secure_debug_enable_in, // from halting control
  input  wire        halted_in,         // processor halted in debug state
  output reg  [31:0] rdata_out,         // read data
  output reg         resp_valid_out,    // answer strobe
  output reg         bus_fault_out,     // bus fault with the answer
  output wire        current_secure_state_out, // security state
  output wire        bank_view_secure_out      // banked view for debugger
);
  wire [2:0]  idx;        // identification index
  wire        id_hit;     // primary identification hit
  wire        al_hit;     // alias hit
  wire        ctl_hit;    // control hit
  wire [31:0] ctl_rdata;  // control read view
  wire        ctl_on;     // control implemented
  wire        id_on;      // identification implemented
  wire        ctl_wr;     // qualified control write
  reg  [31:0] id_word;    // selected identification word
  reg  [31:0] rd_d;       // next read data
  reg         id_vis;     // identification visible to this access

  dsc_addr_decode u_dec
  (
    .addr_in       (addr_in),
    .ident_idx_out (idx),
    .ident_hit_out (id_hit),
    .alias_hit_out (al_hit),
    .ctrl_hit_out  (ctl_hit)
  );

  assign id_on  = (HAS_IDENT != 0) && (HAS_HALT_DEBUG != 0);
  assign ctl_on = (HAS_SECURITY != 0) && (HAS_HALT_DEBUG != 0);
  // control writes only from a privileged debugger access
  assign ctl_wr = req_in && write_in && privileged_in && ctl_hit
                  && from_debugger_in && ctl_on;

  dsc_ctrl_reg u_ctrl
  (
    .ref_clk_in             (ref_clk_in),
    .rst_n_in               (rst_n_in),
    .wr_en_in               (ctl_wr),
    .wdata_in               (wdata_in),
    .secure_debug_enable_in (secure_debug_enable_in),
    .halted_in              (halted_in),
    .secure_state_out       (current_secure_state_out),
    .rdata_out              (ctl_rdata)
  );

  // banked view: non-secure while secure debug is off, else select bit when enabled, else current state
  assign bank_view_secure_out = ctl_rdata[`DSC_BIT_BANK_EN] ?
                                ctl_rdata[`DSC_BIT_BANK_SEL] :
                                current_secure_state_out;

  // identification word contents, one copy for both states
  always @*
  begin
    case (idx)
      3'h0:    id_word = {24'h000000, REVISION_AND, CUSTOMER_MOD};
      3'h1:    id_word = {24'h000000, 4'h0, CONTINUATION};
      default: id_word = 32'h00000000;
    endcase
  end

  // read data selection per access kind
  always @*
  begin
    rd_d = 32'h00000000;
    id_vis = from_debugger_in ||
             !((HAS_MAIN_EXT == 0) && (IDENT_DBG_ONLY != 0));
    if (id_hit && id_on && id_vis)
      rd_d = id_word;
    else if (al_hit && id_on && id_vis && !from_debugger_in && sw_secure_in)
      rd_d = id_word;
    else if (ctl_hit && ctl_on && from_debugger_in)
      rd_d = ctl_rdata;
  end

  // registered answer; writes elsewhere are ignored
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out      <= 32'h00000000;
      resp_valid_out <= 1'b0;
      bus_fault_out  <= 1'b0;
    end
    else
    begin
      resp_valid_out <= req_in;
      bus_fault_out  <= req_in && !privileged_in;
      if (req_in && !write_in && privileged_in)
        rdata_out <= rd_d;
      else
        rdata_out <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// *** testbench/dsc_regbank_props.sv ***
// assertions on the register bank ports
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defs.vh"
module dsc_regbank_props
(
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        req_in,
  input wire logic        write_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        privileged_in,
  input wire logic        from_debugger_in,
  input wire logic        sw_secure_in,
  input wire logic        secure_debug_enable_in,
  input wire logic        halted_in,
  input wire logic [31:0] rdata_out,
  input wire logic        resp_valid_out,
  input wire logic        bus_fault_out,
  input wire logic        current_secure_state_out,
  input wire logic        bank_view_secure_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // qualified debugger write of the state bit
  wire st_wr = req_in && write_in && privileged_in && from_debugger_in && halted_in
    && secure_debug_enable_in && !wdata_in[17] && addr_in == `DSC_ADDR_CTRL;
  wire is_ctrl = req_in && addr_in == `DSC_ADDR_CTRL;
  a_fault_unpriv: assert property (req_in && !privileged_in |=> resp_valid_out && bus_fault_out && rdata_out == 32'h0) else $error("no fault");
  a_no_fault: assert property (req_in && privileged_in |=> !bus_fault_out) else $error("bad fault");
  a_answer_timing: assert property (resp_valid_out == $past(req_in)) else $error("answer timing");
  a_id3_upper: assert property (req_in && addr_in == `DSC_ADDR_ID3 |=> rdata_out[31:8] == 24'h0) else $error("id3 upper");
  a_id4_upper: assert property (req_in && addr_in == `DSC_ADDR_ID4 |=> rdata_out[31:4] == 28'h0) else $error("id4 upper");
  a_reserved_ids: assert property (req_in && addr_in >= `DSC_ADDR_ID5 && addr_in <= `DSC_ADDR_ID7 |=> rdata_out == 32'h0) else $error("id5-7");
  a_alias_hidden: assert property (req_in && (from_debugger_in || !sw_secure_in) && addr_in == `DSC_ADDR_ID3 + `DSC_ALIAS_OFFSET |=> rdata_out == 32'h0) else $error("alias");
  a_ctrl_sw_zero: assert property (is_ctrl && !from_debugger_in |=> rdata_out == 32'h0) else $error("sw ctrl");
  a_key_reads_one: assert property (is_ctrl && !write_in && privileged_in && from_debugger_in |=> rdata_out[17] && rdata_out[31:18] == 14'h0 && rdata_out[15:2] == 14'h0) else $error("key");
  a_state_hold: assert property (!st_wr |=> $stable(current_secure_state_out)) else $error("state moved");
  a_bank_off: assert property (!secure_debug_enable_in |-> !bank_view_secure_out) else $error("bank view");
  c_unpriv: cover property (req_in && !privileged_in);
  c_state_wr: cover property (st_wr);
  c_alias: cover property (req_in && addr_in == `DSC_ADDR_ID3 + `DSC_ALIAS_OFFSET);
endmodule
`default_nettype wire

// *** testbench/dsc_host_model.sv ***
// host model: debugger or software issuing word accesses
`timescale 1ns/1ns
`default_nettype none
module dsc_host_model
(
  input  wire logic        ref_clk_in,
  output var  logic        req_out,
  output var  logic        write_out,
  output var  logic [31:0] addr_out,
  output var  logic [31:0] wdata_out,
  output var  logic        priv_out,
  output var  logic        dbg_out,
  output var  logic        sec_out,
  output var  logic        sde_out,
  output var  logic        halt_out
);
  initial {req_out, write_out, addr_out, wdata_out, priv_out, dbg_out, sec_out} = '0;
  initial {sde_out, halt_out} = 2'b10;
  // one whole word access, held up to its taking edge
  task acc(input logic w, input logic [31:0] a, d, input logic p, g, s);
    @(posedge ref_clk_in);
    {req_out, write_out, priv_out, dbg_out, sec_out} <= {1'b1, w, p, g, s};
    addr_out <= a;
    wdata_out <= d;
    @(posedge ref_clk_in);
    req_out <= 1'b0;
    // released lines show the inverse, not the last value
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // secure debug enable and halt levels
  task mode(input logic e, h);
    @(posedge ref_clk_in);
    {sde_out, halt_out} <= {e, h};
  endtask
endmodule
`default_nettype wire

// *** testbench/dsc_regbank_tb.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defs.vh"
module dsc_regbank_tb;
  logic ref_clk_in, rst_n_in, req, we, priv, dbg, sec, sde, halt, rv, flt, css, bvs;
  logic [31:0] addr, wdata, rdata;
  logic [32:0] q[$]; // expected {fault, data}
  logic [15:0] r;
  int errors, num_checks, i;
  logic [31:0] ids [5] = '{`DSC_ADDR_ID3, `DSC_ADDR_ID4, `DSC_ADDR_ID5,
                           `DSC_ADDR_ID6, `DSC_ADDR_ID7};
  logic [31:0] idv [5] = '{32'ha5, 32'h3, 32'h0, 32'h0, 32'h0};
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input logic [32:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict();
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task rd(input logic [31:0] a, input logic g, s, p, input logic [32:0] e);
    q.push_back(e);
    u_host.acc(1'b0, a, 32'h0, p, g, s);
  endtask
  task wrt(input logic [31:0] a, d, input logic g);
    q.push_back(33'h0);
    u_host.acc(1'b1, a, d, 1'b1, g, 1'b0);
  endtask
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // answers are compared with the oldest note
  always @(posedge ref_clk_in)
    if (rv === 1'b1)
    begin
      if (q.size() == 0) check(33'h0, 33'h1);
      else check({flt, rdata}, q.pop_front());
    end
  initial
  begin
    #100000;
    errors++;
    give_verdict();
  end
  initial
  begin
    rst_n_in = 1'b0;
    r = 16'h9;
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(`DSC_ADDR_CTRL, 1'b1, 1'b0, 1'b1, 33'h30000);
    for (i = 0; i < 5; i++)
    begin
      rd(ids[i], 1'b0, 1'b1, 1'b1, {1'b0, idv[i]});
      rd(ids[i] + `DSC_ALIAS_OFFSET, 1'b0, 1'b1, 1'b1, {1'b0, idv[i]});
      rd(ids[i] + `DSC_ALIAS_OFFSET, 1'b1, 1'b0, 1'b1, 33'h0);
    end
    rd(`DSC_ADDR_ID3, 1'b0, 1'b1, 1'b0, 33'h100000000);
    rd(`DSC_ADDR_CTRL, 1'b0, 1'b1, 1'b1, 33'h0);
    wrt(`DSC_ADDR_CTRL, 32'h0, 1'b1);
    rd(`DSC_ADDR_CTRL, 1'b1, 1'b0, 1'b1, 33'h30000);
    u_host.mode(1'b1, 1'b1);
    wrt(`DSC_ADDR_CTRL, 32'h20003, 1'b1);
    rd(`DSC_ADDR_CTRL, 1'b1, 1'b0, 1'b1, 33'h30003);
    wrt(`DSC_ADDR_CTRL, 32'h3, 1'b1);
    rd(`DSC_ADDR_CTRL, 1'b1, 1'b0, 1'b1, 33'h20003);
    #1 check({32'h0, bvs}, 33'h1);
    check({32'h0, css}, 33'h0);
    wrt(`DSC_ADDR_CTRL, 32'h10000, 1'b0);
    rd(`DSC_ADDR_CTRL, 1'b1, 1'b0, 1'b1, 33'h20003);
    repeat (4)
    begin
      r = lfsr(r);
      wrt(`DSC_ADDR_ID3, {16'h0, r}, 1'b1);
      rd(`DSC_ADDR_ID3, 1'b1, 1'b0, 1'b1, 33'ha5);
      rd(32'h20000000 | {14'h0, r, 2'b00}, 1'b1, 1'b0, 1'b1, 33'h0);
    end
    u_host.mode(1'b0, 1'b1);
    rd(`DSC_ADDR_CTRL, 1'b1, 1'b0, 1'b1, 33'h20001);
    #1 check({32'h0, bvs}, 33'h0);
    check({32'h0, css}, 33'h0);
    // cold reset in mid-run clears select, enable and restores secure state
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    u_host.mode(1'b1, 1'b1);
    rd(`DSC_ADDR_CTRL, 1'b1, 1'b0, 1'b1, 33'h30000);
    #1 check({32'h0, css}, 33'h1);
    repeat (3) @(posedge ref_clk_in);
    // every noted answer must have come back
    check(33'(q.size()), 33'h0);
    give_verdict();
  end
  dsc_host_model u_host (.ref_clk_in(ref_clk_in), .req_out(req), .write_out(we),
    .addr_out(addr), .wdata_out(wdata), .priv_out(priv), .dbg_out(dbg), .sec_out(sec),
    .sde_out(sde), .halt_out(halt));
  dsc_regbank #(.REVISION_AND(4'ha), .CUSTOMER_MOD(4'h5), .CONTINUATION(4'h3)) u_dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_in(req), .write_in(we),
    .addr_in(addr), .wdata_in(wdata), .privileged_in(priv), .from_debugger_in(dbg),
    .sw_secure_in(sec), .secure_debug_enable_in(sde), .halted_in(halt), .rdata_out(rdata),
    .resp_valid_out(rv), .bus_fault_out(flt), .current_secure_state_out(css),
    .bank_view_secure_out(bvs));
endmodule
bind dsc_regbank dsc_regbank_props u_props (.ref_clk_in, .rst_n_in, .req_in, .write_in,
  .addr_in, .wdata_in, .privileged_in, .from_debugger_in, .sw_secure_in,
  .secure_debug_enable_in, .halted_in, .rdata_out, .resp_valid_out, .bus_fault_out,
  .current_secure_state_out, .bank_view_secure_out);
`default_nettype wire
